// file: hw/sadc_pkg.sv
// constants, types and timing counts for the sar converter readout block
// assumes one core clock; pins reach the block through synchronisers
// Summary of operation
// - convert input rising edge starts a new conversion when idle; edges during a conversion are ignored
// - busy goes high when conversion starts, low once it completes
// - chain select low: normal mode, shared pin enables serial output
// - chain select high: shared pin is serial input from upstream converter
// - enabled output shifts result or chain data on shift clock rise, msb first
// - serial output word is two's complement
// - bipolar zero sits at the all-zeros / all-ones boundary
// - strap high: no gain compression, codes span the full bipolar range
// - strap low: rescale by 5/4 so 10% to 90% of range spans full scale
// - normal mode: drive output after read enable falls, release after it rises
// - chain input sampled on shift clock rise; upstream holds it stable there
// - each conversion end prepares a 16-bit code for serial transfer
package sadc_pkg;
   localparam int CLK_PERIOD_NS = 40;
   localparam int T_CONV_MIN_NS = 278;
   localparam int T_CYC_MIN_NS = 500;
   // least time rounds up to whole core cycles
   localparam logic [3:0] CONV_CYC =
      4'((T_CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int CYC_MIN_CYC = (T_CYC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WORD_W = 16;
   localparam int FIFO_DEPTH = 16;
   localparam logic [4:0] WORD_BITS = 5'h10;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [4:0] BIT_ONE = 5'h01;
   localparam logic [4:0] BIT_ZERO = 5'h00;
   localparam logic [15:0] CODE_MAX = 16'h7fff;
   localparam logic [15:0] CODE_MIN = 16'h8000;
   localparam logic [15:0] CODE_ZERO = 16'h0000;
   localparam int SHIFT_MSB = 15;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONV = 2'b01,
      ST_STORE = 2'b10
   } sadc_state_t;
endpackage : sadc_pkg

// file: hw/sadc_fifo.sv
// result buffer between conversion engine and serial shifter
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
module sadc_fifo
   import sadc_pkg::*;
#(
   parameter int WIDTH = WORD_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   localparam logic [AW:0] CNT_INC = (AW+1)'(1);
   localparam logic [AW-1:0] PTR_INC = AW'(1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] mem_next [DEPTH];
   logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic push, pop;

   // honest flags straight off the fill count
   assign in_ready = (cnt_reg != FULL_CNT);
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem_reg[rd_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // pointer and count bookkeeping
   always_comb begin
      mem_next = mem_reg;
      wr_next = wr_reg;
      rd_next = rd_reg;
      cnt_next = cnt_reg;
      if (push) begin
         mem_next[wr_reg] = in_data;
         wr_next = wr_reg + PTR_INC;
      end
      if (pop) begin
         rd_next = rd_reg + PTR_INC;
      end
      if (push && !pop) begin
         cnt_next = cnt_reg + CNT_INC;
      end else if (pop && !push) begin
         cnt_next = cnt_reg - CNT_INC;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= '0;
         end
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         mem_reg <= mem_next;
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
      end
   end
endmodule : sadc_fifo

// file: hw/sadc_top.sv
// conversion control and serial readout of the 16-bit sar converter
// assumes pins and the shift clock are asynchronous to CORE_CLK;
// ANALOG_CODE stands in for the digitised input and is held around convert
`timescale 1ns/1ps
module sadc_top
   import sadc_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic NRST,
   input wire logic CONVERT_TRIGGER,
   input wire logic CHAIN_MODE,
   input wire logic READ_ENABLE_OR_CHAIN_IN,
   input wire logic SHIFT_CLK,
   input wire logic GAIN_COMPRESS_STRAP,
   input wire logic [15:0] ANALOG_CODE,
   output logic BUSY,
   output logic SERIAL_RESULT_OUT,
   output logic SERIAL_RESULT_OUT_OE_N
);
   // synchroniser stages; stage one feeds stage two only
   logic trig_s1, trig_s2, trig_d;
   logic sck_s1, sck_s2, sck_d;
   logic mode_s1, mode_s2;
   logic rdc_s1, rdc_s2;
   logic strap_s1, strap_s2;
   logic [15:0] ain_s1, ain_s2;
   logic trig_rise, sck_rise, shift_en;

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         trig_s1 <= 1'b0;
         trig_s2 <= 1'b0;
         trig_d <= 1'b0;
         sck_s1 <= 1'b0;
         sck_s2 <= 1'b0;
         sck_d <= 1'b0;
         mode_s1 <= 1'b0;
         mode_s2 <= 1'b0;
         rdc_s1 <= 1'b1;
         rdc_s2 <= 1'b1;
         strap_s1 <= 1'b1;
         strap_s2 <= 1'b1;
         ain_s1 <= CODE_ZERO;
         ain_s2 <= CODE_ZERO;
      end else begin
         trig_s1 <= CONVERT_TRIGGER;
         trig_s2 <= trig_s1;
         trig_d <= trig_s2;
         sck_s1 <= SHIFT_CLK;
         sck_s2 <= sck_s1;
         sck_d <= sck_s2;
         mode_s1 <= CHAIN_MODE;
         mode_s2 <= mode_s1;
         rdc_s1 <= READ_ENABLE_OR_CHAIN_IN;
         rdc_s2 <= rdc_s1;
         strap_s1 <= GAIN_COMPRESS_STRAP;
         strap_s2 <= strap_s1;
         ain_s1 <= ANALOG_CODE;
         ain_s2 <= ain_s1;
      end
   end

   // edges seen on the second stage against its delayed copy
   assign trig_rise = trig_s2 && !trig_d;
   assign sck_rise = sck_s2 && !sck_d;
   // chain mode always shifts; normal mode only while read enable is low
   assign shift_en = mode_s2 || !rdc_s2;

   // conversion engine
   sadc_state_t state_reg, state_next;
   logic [3:0] cnt_reg, cnt_next;
   logic busy_reg, busy_next;
   logic [15:0] samp_reg, samp_next;
   logic gcomp_reg, gcomp_next;
   logic push;
   logic [15:0] code;
   logic [16:0] scaled;
   logic fifo_in_ready, fifo_out_valid, pop;
   logic [15:0] fifo_out_data;

   // gain compression stretches by 5/4 so 10%..90% spans full scale
   always_comb begin
      scaled = {samp_reg[15], samp_reg} + {{3{samp_reg[15]}}, samp_reg[15:2]};
      code = samp_reg;
      if (gcomp_reg) begin
         if (scaled[16] != scaled[15]) begin
            code = scaled[16] ? CODE_MIN : CODE_MAX;
         end else begin
            code = scaled[15:0];
         end
      end
   end

   // convert edges during a conversion are ignored; the host spaces them
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      busy_next = busy_reg;
      samp_next = samp_reg;
      gcomp_next = gcomp_reg;
      push = 1'b0;
      unique case (state_reg)
         ST_IDLE: begin
            if (trig_rise) begin
               state_next = ST_CONV;
               cnt_next = CONV_CYC - CNT_ONE;
               samp_next = ain_s2;
               gcomp_next = !strap_s2;
               busy_next = 1'b1;
            end
         end
         ST_CONV: begin
            if (cnt_reg == CNT_ZERO) begin
               state_next = ST_STORE;
            end else begin
               cnt_next = cnt_reg - CNT_ONE;
            end
         end
         ST_STORE: begin
            // a full buffer stalls here with busy still high
            push = 1'b1;
            if (fifo_in_ready) begin
               state_next = ST_IDLE;
               busy_next = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         state_reg <= ST_IDLE;
         cnt_reg <= CNT_ZERO;
         busy_reg <= 1'b0;
         samp_reg <= CODE_ZERO;
         gcomp_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         busy_reg <= busy_next;
         samp_reg <= samp_next;
         gcomp_reg <= gcomp_next;
      end
   end

   sadc_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) sadc_fifo_inst (
      .clk(CORE_CLK),
      .rst_n(NRST),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(code),
      .out_valid(fifo_out_valid),
      .out_ready(pop),
      .out_data(fifo_out_data)
   );

   // serial shifter; a new word loads only once 16 bits have left
   logic [15:0] sr_reg, sr_next;
   logic [4:0] bits_reg, bits_next;
   logic dout_reg, dout_next, oen_reg, oen_next;

   always_comb begin
      sr_next = sr_reg;
      bits_next = bits_reg;
      pop = 1'b0;
      if (sck_rise && shift_en) begin
         // chain data enters at the bottom and trails the own word
         sr_next = {sr_reg[14:0], mode_s2 && rdc_s2};
         if (bits_reg != WORD_BITS) begin
            bits_next = bits_reg + BIT_ONE;
         end
      end else if (fifo_out_valid && bits_reg == WORD_BITS) begin
         // limitation: in chain mode unread chain bits are replaced here
         pop = 1'b1;
         sr_next = fifo_out_data;
         bits_next = BIT_ZERO;
      end
      dout_next = sr_next[SHIFT_MSB];
      oen_next = mode_s2 ? 1'b0 : rdc_s2;
   end

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         sr_reg <= CODE_ZERO;
         bits_reg <= WORD_BITS;
         dout_reg <= 1'b0;
         oen_reg <= 1'b1;
      end else begin
         sr_reg <= sr_next;
         bits_reg <= bits_next;
         dout_reg <= dout_next;
         oen_reg <= oen_next;
      end
   end

   assign BUSY = busy_reg;
   assign SERIAL_RESULT_OUT = dout_reg;
   assign SERIAL_RESULT_OUT_OE_N = oen_reg;

   // checks on the block's own behaviour
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);

   a_conv_start: assert property (
      (state_reg == ST_IDLE && trig_rise) |=> busy_reg && state_reg == ST_CONV)
      else $error("convert edge did not start a conversion");
   a_busy_len: assert property (
      $rose(busy_reg) |-> busy_reg [*7] ##1 (state_reg == ST_STORE))
      else $error("busy shorter than conversion time");
   a_busy_fall: assert property (
      $fell(busy_reg) |-> $past(push && fifo_in_ready))
      else $error("busy fell without a stored result");
   a_oe_normal: assert property (
      !$past(mode_s2) |-> SERIAL_RESULT_OUT_OE_N == $past(rdc_s2))
      else $error("normal mode output enable does not follow read enable");
   a_oe_chain: assert property (
      $past(mode_s2) |-> !SERIAL_RESULT_OUT_OE_N)
      else $error("chain mode output not driven");
   a_shift_msb: assert property (
      (sck_rise && shift_en) |=> SERIAL_RESULT_OUT == $past(sr_reg[14]))
      else $error("shift did not present next lower bit");
   a_chain_in: assert property (
      (sck_rise && mode_s2) |=> sr_reg[0] == $past(rdc_s2))
      else $error("chain input bit not captured on shift edge");
   a_plain_code: assert property (
      (push && !gcomp_reg) |-> code == samp_reg)
      else $error("uncompressed code differs from sample");
   a_zero_code: assert property (
      (push && samp_reg == CODE_ZERO) |-> code == CODE_ZERO)
      else $error("bipolar zero not coded as zero");
   a_gcomp_sat: assert property (
      (push && gcomp_reg && samp_reg == CODE_MAX) |-> code == CODE_MAX)
      else $error("compressed full scale not saturated");
   a_load_word: assert property (
      pop |=> bits_reg == BIT_ZERO && SERIAL_RESULT_OUT == $past(fifo_out_data[15]))
      else $error("loaded word msb not presented");

   c_conversion: cover property ($fell(busy_reg));
   c_chain_shift: cover property (sck_rise && mode_s2 && bits_reg == WORD_BITS);
   c_gcomp_push: cover property (push && gcomp_reg);
   c_fifo_full: cover property (push && !fifo_in_ready);
endmodule : sadc_top

// file: bench/sadc_host.sv
// host model: convert pulses, shift clock and the shared read/chain pin
// assumes a free-running bench clock and the block's busy output
`timescale 1ns/1ps
module sadc_host (
   input wire logic clk,
   input wire logic busy,
   output logic trig,
   output logic sck,
   output logic rdc
);
   initial begin
      trig = 1'b0;
      sck = 1'b0; // shift clock stands still between frames
      rdc = 1'b1;
   end
   // all changes land just after a rising edge
   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick
   // one conversion; ok stays low if busy never rises or never falls
   task automatic convert(output logic ok);
      int n;
      ok = 1'b0;
      repeat (4) tick();
      trig = 1'b1;
      for (n = 0; n < 20 && busy !== 1'b1; n++) tick();
      if (n == 20) return;
      trig = 1'b0;
      for (n = n; n < 420 && busy !== 1'b0; n++) tick();
      ok = (busy === 1'b0);
      // pad so convert edges never come closer than the cycle time
      while (n < 13) begin
         tick();
         n++;
      end
   endtask : convert
   // one 320 ns shift period; next chain bit changes at the fall, far from the rise
   task automatic shift(input logic din);
      sck = 1'b1;
      repeat (4) tick();
      sck = 1'b0;
      rdc = din;
      repeat (4) tick();
   endtask : shift
   task automatic level(input logic v);
      rdc = v;
   endtask : level
endmodule : sadc_host

// file: bench/test_sadc_top.sv
// self-checking bench for the converter readout block
// assumes the host model drives convert, shift clock and the shared pin
`timescale 1ns/1ps
module test_sadc_top;
   import sadc_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic mode = 1'b0;
   logic strap = 1'b1;
   logic [15:0] code = 16'h0000;
   logic busy, dout, oe_n, trig, sck, rdc, ok;
   int mismatches = 0;
   int num_checks = 0;
   logic [15:0] q[$];
   logic [16:0] corner [9] = '{17'h1_0000, 17'h1_ffff, 17'h1_7fff, 17'h1_8000,
      17'h0_7ffc, 17'h0_8000, 17'h0_fffc, 17'h0_0004, 17'h0_7fff};
   always #20 clk = ~clk;
   sadc_top sadc_top_inst (.CORE_CLK(clk), .NRST(nrst), .CONVERT_TRIGGER(trig),
      .CHAIN_MODE(mode), .READ_ENABLE_OR_CHAIN_IN(rdc), .SHIFT_CLK(sck),
      .GAIN_COMPRESS_STRAP(strap), .ANALOG_CODE(code), .BUSY(busy),
      .SERIAL_RESULT_OUT(dout), .SERIAL_RESULT_OUT_OE_N(oe_n));
   sadc_host sadc_host_inst (.clk(clk), .busy(busy), .trig(trig), .sck(sck), .rdc(rdc));
   // random compressed codes are multiples of four; the odd corner saturates
   function automatic logic [15:0] expect_code(logic [15:0] x, logic s);
      int v;
      v = $signed(x);
      if (s) return x;
      v = v * 5 / 4;
      if (v > 32767) return CODE_MAX;
      if (v < -32768) return CODE_MIN;
      return v[15:0];
   endfunction : expect_code
   task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : conclude
   // expectation is queued first so a concurrent reader sees it in order
   task automatic conv(logic [15:0] x, logic s);
      code = x;
      strap = s;
      q.push_back(expect_code(x, s));
      sadc_host_inst.convert(ok);
      chk("busy handshake", {15'h0000, ok}, 16'h0001);
      if (ok !== 1'b1) conclude();
   endtask : conv
   task automatic rnd_conv();
      logic [15:0] x;
      logic s;
      x = 16'($urandom);
      s = 1'($urandom);
      if (!s) x = x & 16'hfffc;
      conv(x, s);
   endtask : rnd_conv
   task automatic read_words(int n);
      logic [15:0] w;
      sadc_host_inst.level(1'b0);
      repeat (6) sadc_host_inst.tick();
      chk("oe_n on", {15'h0000, oe_n}, 16'h0000);
      repeat (n) begin
         for (int i = 0; i < 16; i++) begin
            w = {w[14:0], dout};
            sadc_host_inst.shift(1'b0);
         end
         chk("word", w, q.pop_front());
      end
      sadc_host_inst.level(1'b1);
      repeat (6) sadc_host_inst.tick();
      chk("oe_n off", {15'h0000, oe_n}, 16'h0001);
   endtask : read_words
   initial begin
      logic [31:0] cb, got;
      logic [15:0] e;
      void'($urandom(32'ha7d4));
      repeat (10) @(posedge clk);
      #1 nrst = 1'b1;
      repeat (3) sadc_host_inst.tick();
      chk("busy reset", {15'h0000, busy}, 16'h0000);
      // corner codes; edges with the output disabled must not shift
      foreach (corner[i]) begin
         conv(corner[i][15:0], corner[i][16]);
         repeat (3) sadc_host_inst.shift(1'b1);
         chk("oe_n idle", {15'h0000, oe_n}, 16'h0001);
         read_words(1);
      end
      $display("test corner done");
      // fill shifter and buffer, then one more that must wait for room
      repeat (17) rnd_conv();
      fork
         rnd_conv();
         read_words(18);
      join
      $display("test fill done");
      mode = 1'b1;
      repeat (6) sadc_host_inst.tick();
      chk("oe_n chain", {15'h0000, oe_n}, 16'h0000);
      repeat (2) begin
         cb = $urandom;
         rnd_conv();
         sadc_host_inst.level(cb[0]);
         repeat (4) sadc_host_inst.tick();
         for (int j = 0; j < 32; j++) begin
            got = {got[30:0], dout};
            sadc_host_inst.shift(j < 31 ? cb[j + 1] : 1'b0);
         end
         for (int k = 0; k < 16; k++) e[15 - k] = cb[k];
         chk("chain own", got[31:16], q.pop_front());
         chk("chain passed", got[15:0], e);
      end
      $display("test chain done");
      conclude();
   end
endmodule : test_sadc_top
